// [fkl_top.sv]
// flash key lock, emulation copy engine, staging fifo and ahb-lite slave
`timescale 1ns/10ps
`include "fkl_regs.svh"

module fkl_fifo #(
  parameter int W = 8,
  parameter int D = `FKL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int A = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [A:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic push, pop;

  assign in_ready = !(wp_ff[A] != rp_ff[A] && wp_ff[A-1:0] == rp_ff[A-1:0]);
  assign out_valid = wp_ff != rp_ff;
  assign out_data = mem[rp_ff[A-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
  end

  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wp_ff[A-1:0]] <= in_data;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
    end
    else
    begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end
endmodule : fkl_fifo

module fkl_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // flash array
  output logic fl_req,
  output logic fl_we,
  output logic fl_erase,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic fl_ack,
  input wire logic [7:0] fl_rdata,
  // status
  output fkl_pkg::fkl_lock_e flash_lock_state,
  output logic ee_busy
);
  import fkl_pkg::*;
  // bit view of the control reset word, so reset picks single bits without truncation
  localparam logic [7:0] CTRL_RST = `FKL_CTRL_RST;

  function automatic logic is_idx(input logic [9:0] a, input logic [9:0] idx);
    is_idx = a == idx;
  endfunction : is_idx

  function automatic logic [15:0] ee_fl(input logic [5:0] i);
    ee_fl = `FKL_EE_FL_BASE + {10'h000, i};
  endfunction : ee_fl

  fkl_lock_e lock_ff, nxt_lock;
  fkl_eng_e eng_ff, nxt_eng;
  logic ps_we_ff, nxt_ps_we, ps_ee_ff, nxt_ps_ee;
  logic ee_en_ff, nxt_ee_en, ee_auto_ff, nxt_ee_auto;
  logic [15:0] fa_ff, nxt_fa, fl_addr_ff, nxt_fl_addr;
  logic [4:0] ee_addr_ff, nxt_ee_addr, rd_ea;
  logic [5:0] iss_ff, nxt_iss, drn_ff, nxt_drn;
  logic fl_req_ff, nxt_fl_req, fl_we_ff, nxt_fl_we, fl_erase_ff, nxt_fl_erase;
  logic [7:0] fl_wdata_ff, nxt_fl_wdata, wd;
  logic wr_pend_ff, nxt_wr_pend;
  logic [9:0] wr_idx_ff, nxt_wr_idx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic ap, rd_now, key_wr, attempt, wr_step, rd_step;
  logic ram_we;
  logic [4:0] ram_wa;
  logic [7:0] ram_wd;
  logic [7:0] ram_mem [0:31];
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_in_data, f_out_data;

  assign ap = hsel && htrans[1] && hready;
  assign rd_now = ap && !hwrite;
  assign wd = hwdata[7:0];
  assign key_wr = wr_pend_ff && is_idx(wr_idx_ff, `FKL_IDX_KEY);
  // a data write only counts as a flash attempt with write enable set
  assign attempt = wr_pend_ff && is_idx(wr_idx_ff, `FKL_IDX_FDATA) && ps_we_ff;
  // bus writes to ram are dropped while the copy engine runs; bus reads are not gated
  assign wr_step = wr_pend_ff && is_idx(wr_idx_ff, `FKL_IDX_EDATA) && ee_en_ff
                   && eng_ff == FKL_IDLE;
  assign rd_step = rd_now && is_idx(haddr[11:2], `FKL_IDX_EDATA) && ee_en_ff;
  assign rd_ea = (wr_step && ee_auto_ff) ? ee_addr_ff + 5'h01 : ee_addr_ff;

  fkl_fifo #(
    .W(8),
    .D(`FKL_FIFO_DEPTH)
  ) i_fkl_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_comb
  begin
    nxt_lock = lock_ff;
    nxt_eng = eng_ff;
    nxt_ps_we = ps_we_ff;
    nxt_ps_ee = ps_ee_ff;
    nxt_ee_en = ee_en_ff;
    nxt_ee_auto = ee_auto_ff;
    nxt_fa = fa_ff;
    nxt_ee_addr = ee_addr_ff;
    nxt_iss = iss_ff;
    nxt_drn = drn_ff;
    nxt_fl_req = fl_req_ff;
    nxt_fl_we = fl_we_ff;
    nxt_fl_erase = fl_erase_ff;
    nxt_fl_addr = fl_addr_ff;
    nxt_fl_wdata = fl_wdata_ff;
    nxt_wr_pend = ap && hwrite;
    nxt_wr_idx = haddr[11:2];
    nxt_hrdata = 32'h00000000;
    ram_we = 1'b0;
    ram_wa = ee_addr_ff;
    ram_wd = wd;
    f_in_valid = 1'b0;
    f_in_data = fl_rdata;
    f_out_ready = 1'b0;
    unique case (eng_ff)
      FKL_IDLE: ;
      FKL_SW_OP:
        if (fl_ack)
        begin
          nxt_fl_req = 1'b0;
          nxt_eng = FKL_IDLE;
          if (lock_ff == FKL_OPEN)
            nxt_lock = FKL_LOCKED;
        end
      FKL_CP_RD:
      begin
        f_out_ready = 1'b1;
        if (f_out_valid)
        begin
          ram_we = 1'b1;
          ram_wa = drn_ff[4:0];
          ram_wd = f_out_data;
          nxt_drn = drn_ff + 6'h01;
          if (drn_ff == `FKL_EE_LAST)
            nxt_eng = FKL_IDLE;
        end
        if (!fl_req_ff && iss_ff != `FKL_EE_BYTES && f_in_ready)
        begin
          nxt_fl_req = 1'b1;
          nxt_fl_we = 1'b0;
          nxt_fl_erase = 1'b0;
          nxt_fl_addr = ee_fl(iss_ff);
        end
        if (fl_req_ff && fl_ack)
        begin
          nxt_fl_req = 1'b0;
          f_in_valid = 1'b1;
          nxt_iss = iss_ff + 6'h01;
        end
      end
      FKL_CP_WR:
      begin
        if (iss_ff != `FKL_EE_BYTES)
        begin
          f_in_valid = 1'b1;
          f_in_data = ram_mem[iss_ff[4:0]];
          if (f_in_ready)
            nxt_iss = iss_ff + 6'h01;
        end
        if (!fl_req_ff && f_out_valid)
        begin
          f_out_ready = 1'b1;
          nxt_fl_req = 1'b1;
          nxt_fl_we = 1'b1;
          nxt_fl_erase = 1'b0;
          nxt_fl_addr = ee_fl(drn_ff);
          nxt_fl_wdata = f_out_data;
        end
        if (fl_req_ff && fl_ack)
        begin
          nxt_fl_req = 1'b0;
          nxt_drn = drn_ff + 6'h01;
          if (drn_ff == `FKL_EE_LAST)
            nxt_eng = FKL_IDLE;
        end
      end
    endcase
    if (rd_now)
    begin
      if (is_idx(haddr[11:2], `FKL_IDX_KEY))
        nxt_hrdata = {30'h0, lock_ff};
      else if (is_idx(haddr[11:2], `FKL_IDX_CTRL))
        nxt_hrdata = {24'h000000, ee_en_ff, 4'h0, eng_ff == FKL_CP_RD,
                      eng_ff == FKL_CP_WR, ee_auto_ff};
      else if (is_idx(haddr[11:2], `FKL_IDX_PSC))
        nxt_hrdata = {30'h0, ps_ee_ff, ps_we_ff};
      else if (is_idx(haddr[11:2], `FKL_IDX_FADR_LO))
        nxt_hrdata = {24'h000000, fa_ff[7:0]};
      else if (is_idx(haddr[11:2], `FKL_IDX_FADR_HI))
        nxt_hrdata = {24'h000000, fa_ff[15:8]};
      else if (is_idx(haddr[11:2], `FKL_IDX_EADR))
        nxt_hrdata = {27'h0, ee_addr_ff};
      else if (rd_step)
        nxt_hrdata = {24'h000000, ram_mem[rd_ea]};
    end
    if (ee_auto_ff)
      nxt_ee_addr = ee_addr_ff + {4'h0, wr_step} + {4'h0, rd_step};
    if (wr_step)
      ram_we = 1'b1;
    if (key_wr)
    begin
      unique case (lock_ff)
        FKL_LOCKED: nxt_lock = (wd == `FKL_KEY_FIRST) ? FKL_KEY1 : FKL_DEAD;
        FKL_KEY1: nxt_lock = (wd == `FKL_KEY_SECOND) ? FKL_OPEN : FKL_DEAD;
        FKL_OPEN: nxt_lock = FKL_DEAD;
        FKL_DEAD: nxt_lock = FKL_DEAD;
      endcase
    end
    if (attempt)
    begin
      if (lock_ff != FKL_OPEN)
        nxt_lock = FKL_DEAD;
      else if (eng_ff == FKL_IDLE)
      begin
        nxt_eng = FKL_SW_OP;
        nxt_fl_req = 1'b1;
        nxt_fl_we = !ps_ee_ff;
        nxt_fl_erase = ps_ee_ff;
        nxt_fl_addr = fa_ff;
        nxt_fl_wdata = wd;
      end
    end
    if (wr_pend_ff)
    begin
      if (is_idx(wr_idx_ff, `FKL_IDX_CTRL) && eng_ff == FKL_IDLE)
      begin
        nxt_ee_en = wd[`FKL_CTRL_EN];
        nxt_ee_auto = wd[`FKL_CTRL_AUTO];
        nxt_iss = 6'h00;
        nxt_drn = 6'h00;
        if (wd[`FKL_CTRL_EN] && wd[`FKL_CTRL_RD])
          nxt_eng = FKL_CP_RD;
        else if (wd[`FKL_CTRL_EN] && wd[`FKL_CTRL_WR])
          nxt_eng = FKL_CP_WR;
      end
      if (is_idx(wr_idx_ff, `FKL_IDX_PSC))
      begin
        nxt_ps_we = wd[`FKL_PSC_WE];
        nxt_ps_ee = wd[`FKL_PSC_EE];
      end
      if (is_idx(wr_idx_ff, `FKL_IDX_FADR_LO))
        nxt_fa = {fa_ff[15:8], wd};
      if (is_idx(wr_idx_ff, `FKL_IDX_FADR_HI))
        nxt_fa = {wd, fa_ff[7:0]};
      if (is_idx(wr_idx_ff, `FKL_IDX_EADR))
        nxt_ee_addr = wd[4:0];
    end
  end

  always_ff @(posedge hclk)
  begin
    if (ram_we)
      ram_mem[ram_wa] <= ram_wd;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_ff <= FKL_LOCKED;
      eng_ff <= FKL_IDLE;
      ps_we_ff <= 1'b0;
      ps_ee_ff <= 1'b0;
      ee_en_ff <= CTRL_RST[`FKL_CTRL_EN];
      ee_auto_ff <= CTRL_RST[`FKL_CTRL_AUTO];
      fa_ff <= 16'h0000;
      ee_addr_ff <= 5'h00;
      iss_ff <= 6'h00;
      drn_ff <= 6'h00;
      fl_req_ff <= 1'b0;
      fl_we_ff <= 1'b0;
      fl_erase_ff <= 1'b0;
      fl_addr_ff <= 16'h0000;
      fl_wdata_ff <= 8'h00;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 10'h000;
      hrdata_ff <= 32'h00000000;
    end
    else
    begin
      lock_ff <= nxt_lock;
      eng_ff <= nxt_eng;
      ps_we_ff <= nxt_ps_we;
      ps_ee_ff <= nxt_ps_ee;
      ee_en_ff <= nxt_ee_en;
      ee_auto_ff <= nxt_ee_auto;
      fa_ff <= nxt_fa;
      ee_addr_ff <= nxt_ee_addr;
      iss_ff <= nxt_iss;
      drn_ff <= nxt_drn;
      fl_req_ff <= nxt_fl_req;
      fl_we_ff <= nxt_fl_we;
      fl_erase_ff <= nxt_fl_erase;
      fl_addr_ff <= nxt_fl_addr;
      fl_wdata_ff <= nxt_fl_wdata;
      wr_pend_ff <= nxt_wr_pend;
      wr_idx_ff <= nxt_wr_idx;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // zero wait states keep the slave simple; hsize is not decoded
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign fl_req = fl_req_ff;
  assign fl_we = fl_we_ff;
  assign fl_erase = fl_erase_ff;
  assign fl_addr = fl_addr_ff;
  assign fl_wdata = fl_wdata_ff;
  assign flash_lock_state = lock_ff;
  assign ee_busy = eng_ff != FKL_IDLE;

  key_second_a: assert property (@(posedge hclk) disable iff (!hresetn)
    key_wr && lock_ff == FKL_KEY1 && wd == `FKL_KEY_SECOND |=> lock_ff == FKL_OPEN)
    else $error("second key did not unlock");
  relock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eng_ff == FKL_SW_OP && fl_ack && lock_ff == FKL_OPEN && !key_wr
    |=> lock_ff == FKL_LOCKED && !fl_req)
    else $error("flash stayed unlocked after operation");
  bad_key_a: assert property (@(posedge hclk) disable iff (!hresetn)
    key_wr && lock_ff == FKL_LOCKED && wd != `FKL_KEY_FIRST |=> lock_ff == FKL_DEAD)
    else $error("wrong first key not punished");
  dead_stays_a: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_ff == FKL_DEAD |=> lock_ff == FKL_DEAD [*3])
    else $error("dead lock left before reset");
  no_perm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    attempt && lock_ff != FKL_OPEN |=> lock_ff == FKL_DEAD && eng_ff != FKL_SW_OP)
    else $error("locked attempt not suppressed");
  lock_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_now && is_idx(haddr[11:2], `FKL_IDX_KEY)
    |=> hrdata == {30'h0, $past(lock_ff)})
    else $error("lock state read wrong");
  copy_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eng_ff == FKL_CP_RD || eng_ff == FKL_CP_WR |-> ee_en_ff)
    else $error("copy running while disabled");
  copy_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(eng_ff) == FKL_CP_RD && eng_ff == FKL_IDLE |-> drn_ff == `FKL_EE_BYTES)
    else $error("flash to ram copy length wrong");
  ctrl_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_now && is_idx(haddr[11:2], `FKL_IDX_CTRL) |=> hrdata[6:3] == 4'h0)
    else $error("reserved control bits not zero");
  auto_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_step && !wr_step && ee_auto_ff && !(wr_pend_ff && is_idx(wr_idx_ff, `FKL_IDX_EADR))
    |=> ee_addr_ff == $past(ee_addr_ff) + 5'h01)
    else $error("byte address did not step");
  op_perm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eng_ff == FKL_SW_OP && $past(eng_ff) == FKL_IDLE
    |-> $past(ps_we_ff) && $past(lock_ff) == FKL_OPEN && fl_erase == $past(ps_ee_ff))
    else $error("flash operation started without permission");
endmodule : fkl_top

// [fkl_regs.svh]
// register indices, field positions, reset values and constants of the flash key block
`ifndef FKL_REGS_SVH
`define FKL_REGS_SVH
`define FKL_IDX_KEY 10'h0B7
`define FKL_IDX_CTRL 10'h0C5
`define FKL_IDX_PSC 10'h010
`define FKL_IDX_FADR_LO 10'h011
`define FKL_IDX_FADR_HI 10'h012
`define FKL_IDX_FDATA 10'h013
`define FKL_IDX_EADR 10'h014
`define FKL_IDX_EDATA 10'h015
`define FKL_KEY_FIRST 8'hA5
`define FKL_KEY_SECOND 8'hF1
`define FKL_CTRL_EN 7
`define FKL_CTRL_RD 2
`define FKL_CTRL_WR 1
`define FKL_CTRL_AUTO 0
`define FKL_CTRL_RST 8'h01
`define FKL_PSC_WE 0
`define FKL_PSC_EE 1
`define FKL_EE_FL_BASE 16'h1E00
`define FKL_EE_BYTES 6'h20
`define FKL_EE_LAST 6'h1F
`define FKL_FIFO_DEPTH 8
`endif

// [fkl_pkg.sv]
// types of the flash key and emulation block
package fkl_pkg;
  typedef enum logic [1:0] {FKL_LOCKED, FKL_KEY1, FKL_OPEN, FKL_DEAD} fkl_lock_e;
  typedef enum logic [1:0] {FKL_IDLE, FKL_SW_OP, FKL_CP_RD, FKL_CP_WR} fkl_eng_e;
endpackage : fkl_pkg

// [fkl_flash_model.sv]
// behavioural flash array with alternating prompt and slow acknowledge
`timescale 1ns/10ps
module fkl_flash_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request from the block
  input wire logic fl_req,
  input wire logic fl_we,
  input wire logic fl_erase,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  // answer
  output logic fl_ack,
  output logic [7:0] fl_rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt;
  logic slow;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end

  // only the low address byte is kept; the array acts as one erase page
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fl_ack <= 1'b0;
      cnt <= 2'h0;
      slow <= 1'b0;
      fl_rdata <= 8'h00;
    end
    else if (fl_ack)
    begin
      fl_ack <= 1'b0;
      cnt <= 2'h0;
      slow <= ~slow;
      fl_rdata <= ~fl_rdata;
    end
    else if (fl_req && cnt == (slow ? 2'h3 : 2'h0))
    begin
      fl_ack <= 1'b1;
      fl_rdata <= mem[fl_addr[7:0]];
      if (fl_erase)
        for (int i = 0; i < 256; i++)
          mem[i] <= 8'hFF;
      // programming only clears bits, as real cells do
      else if (fl_we)
        mem[fl_addr[7:0]] <= mem[fl_addr[7:0]] & fl_wdata;
    end
    else
    begin
      cnt <= cnt + (fl_req ? 2'h1 : 2'h0);
      fl_rdata <= ~fl_rdata;
    end
  end
endmodule : fkl_flash_model

// [fkl_top_tb.sv]
// self-checking bench of the flash key and emulation block
`timescale 1ns/10ps
`include "fkl_regs.svh"
module fkl_top_tb;
  import fkl_pkg::*;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, fl_req, fl_we, fl_erase, fl_ack, ee_busy;
  logic [15:0] fl_addr;
  logic [7:0] fl_wdata, fl_rdata;
  fkl_lock_e flash_lock_state;
  logic dp_rd = 0;
  logic [7:0] exp_q[$];
  logic [7:0] d[32];
  logic [31:0] seed = 32'h92F9842A;
  int n_fail = 0;
  int checks_done = 0;
  int n_ops = 0;
  int cyc = 0;
  int ops0;

  initial
  begin
    forever #5 hclk = ~hclk;
  end

  fkl_top i_fkl_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fl_req(fl_req), .fl_we(fl_we),
    .fl_erase(fl_erase), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack),
    .fl_rdata(fl_rdata), .flash_lock_state(flash_lock_state), .ee_busy(ee_busy));

  fkl_flash_model i_fkl_flash_model (.hclk(hclk), .hresetn(hresetn), .fl_req(fl_req),
    .fl_we(fl_we), .fl_erase(fl_erase), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_ack(fl_ack), .fl_rdata(fl_rdata));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // read data is judged in its data phase, oldest note first
  always @(posedge hclk)
  begin
    if (dp_rd === 1'b1 && hreadyout === 1'b1)
    begin
      chk("hrdata", exp_q.pop_front(), hrdata[7:0]);
      chk("hrdata upper", 8'h00, hrdata[31:24] | hrdata[23:16] | hrdata[15:8]);
      chk("hresp", 8'h00, {7'h00, hresp});
    end
  end

  always @(posedge hclk)
  begin
    cyc++;
    if (fl_req === 1'b1 && fl_ack === 1'b1)
      n_ops++;
    if (cyc == 30000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] v);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    dp_rd <= ~wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    dp_rd <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    bus(1'b1, i, v);
  endtask : wr

  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, i, 8'h00);
  endtask : rd

  task automatic rst();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : rst

  // busy rises on the clock edge that ends the data phase, so give it time first
  task automatic idle();
    repeat (3) @(posedge hclk);
    while (ee_busy !== 1'b0)
      @(posedge hclk);
  endtask : idle

  task automatic fop(input logic [7:0] psc, input logic [7:0] v);
    wr(`FKL_IDX_PSC, psc);
    wr(`FKL_IDX_KEY, `FKL_KEY_FIRST);
    rd(`FKL_IDX_KEY, 8'h01);
    wr(`FKL_IDX_KEY, `FKL_KEY_SECOND);
    rd(`FKL_IDX_KEY, 8'h02);
    wr(`FKL_IDX_FDATA, v);
    idle();
    rd(`FKL_IDX_KEY, 8'h00);
  endtask : fop

  initial
  begin
    rst();
    rd(`FKL_IDX_KEY, 8'h00);
    rd(`FKL_IDX_CTRL, `FKL_CTRL_RST);
    rd(10'h3FF, 8'h00);
    wr(`FKL_IDX_FADR_LO, 8'h40);
    wr(`FKL_IDX_FADR_HI, 8'h1E);
    d[0] = rnd();
    fop(8'h03, 8'h00);
    chk("erase", 8'hFF, i_fkl_flash_model.mem[8'h40]);
    fop(8'h01, d[0]);
    chk("program", d[0], i_fkl_flash_model.mem[8'h40]);
    rd(`FKL_IDX_PSC, 8'h01);
    wr(`FKL_IDX_CTRL, 8'h01);
    wr(`FKL_IDX_EDATA, 8'h5A);
    rd(`FKL_IDX_EDATA, 8'h00);
    ops0 = n_ops;
    wr(`FKL_IDX_CTRL, 8'h06);
    idle();
    chk("ops", ops0[7:0], n_ops[7:0]);
    wr(`FKL_IDX_CTRL, 8'hF1);
    rd(`FKL_IDX_CTRL, 8'h81);
    wr(`FKL_IDX_EADR, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      d[i] = rnd();
      wr(`FKL_IDX_EDATA, d[i]);
    end
    rd(`FKL_IDX_EADR, 8'h00);
    wr(`FKL_IDX_CTRL, 8'h83);
    idle();
    for (int i = 0; i < 32; i++)
      chk("copy out", d[i], i_fkl_flash_model.mem[i]);
    for (int i = 0; i < 32; i++)
      wr(`FKL_IDX_EDATA, ~d[i]);
    wr(`FKL_IDX_CTRL, 8'h85);
    idle();
    rd(`FKL_IDX_CTRL, 8'h81);
    for (int i = 0; i < 32; i++)
      rd(`FKL_IDX_EDATA, d[i]);
    wr(`FKL_IDX_CTRL, 8'h80);
    wr(`FKL_IDX_EADR, 8'h05);
    rd(`FKL_IDX_EDATA, d[5]);
    rd(`FKL_IDX_EDATA, d[5]);
    rd(`FKL_IDX_EADR, 8'h05);
    for (int k = 0; k < 4; k++)
    begin
      rst();
      ops0 = n_ops;
      wr(`FKL_IDX_PSC, 8'h01);
      if (k == 0)
      begin
        wr(`FKL_IDX_KEY, `FKL_KEY_FIRST);
        wr(`FKL_IDX_KEY, `FKL_KEY_FIRST);
      end
      if (k == 2)
        wr(`FKL_IDX_KEY, 8'h5A ^ (rnd() & 8'h0F));
      if (k == 3)
      begin
        wr(`FKL_IDX_KEY, `FKL_KEY_FIRST);
        wr(`FKL_IDX_KEY, `FKL_KEY_SECOND);
        wr(`FKL_IDX_KEY, `FKL_KEY_FIRST);
      end
      wr(`FKL_IDX_FDATA, 8'h00);
      idle();
      rd(`FKL_IDX_KEY, 8'h03);
      wr(`FKL_IDX_KEY, `FKL_KEY_FIRST);
      wr(`FKL_IDX_KEY, `FKL_KEY_SECOND);
      wr(`FKL_IDX_FDATA, 8'h00);
      idle();
      chk("state", 8'h03, {6'h00, flash_lock_state});
      chk("ops", ops0[7:0], n_ops[7:0]);
    end
    repeat (2) @(posedge hclk);
    test_done();
  end
endmodule : fkl_top_tb
